// [logic/jesd_align_pkg.sv]
// Purpose: Shared constants and types for the lane alignment and framing block
// Assumes: One octet (8B/10B) or one 64-bit block (64B/66B) per lane per clock
// Notes:   Control codes are the octet values ahead of the 8B/10B encoder
package jesd_align_pkg;
   localparam int          LANES            = 4;
   localparam int          ILAS_MULTIFRAMES = 4;
   localparam int          BLOCKS_PER_MB    = 32;
   localparam int          OCTETS_PER_BLOCK = 8;
   localparam int          SH_BITS          = 2;
   localparam int          CLK_PERIOD_NS    = 100;

   localparam logic [7:0]  K28_0            = 8'h1C;
   localparam logic [7:0]  K28_3            = 8'h7C;
   localparam logic [7:0]  K28_4            = 8'h9C;
   localparam logic [7:0]  K28_5            = 8'hBC;
   localparam logic [7:0]  K28_7            = 8'hFC;
   localparam logic [7:0]  FRAME_END_MATCH  = K28_7;
   localparam logic [7:0]  MF_END_MATCH     = K28_3;

   localparam logic [14:0] SCR8_SEED        = 15'h7FFF;
   localparam int          SCR8_TAP_A       = 13;
   localparam int          SCR8_TAP_B       = 14;
   localparam logic [57:0] SCR66_SEED       = 58'h3FFFFFFFFFFFFFF;
   localparam int          SCR66_TAP_A      = 38;
   localparam int          SCR66_TAP_B      = 57;

   localparam logic [1:0]  SH_ONE           = 2'h2;
   localparam logic [1:0]  SH_ZERO          = 2'h1;

   localparam logic [9:0]  ILAS_Q_POS       = 10'h001;
   localparam logic [9:0]  ILAS_CFG_POS     = 10'h002;
   localparam logic [9:0]  ILAS_CFG_LEN     = 10'h006;
   localparam logic [1:0]  ILAS_CFG_MF      = 2'h1;
   localparam logic [1:0]  ILAS_LAST_MF     = 2'(ILAS_MULTIFRAMES - 1);
   localparam logic [4:0]  MB_LAST_BLOCK    = 5'(BLOCKS_PER_MB - 1);

   typedef enum logic [1:0] {
      PH_CGS  = 2'b00,
      PH_WAIT = 2'b01,
      PH_ILAS = 2'b10,
      PH_DATA = 2'b11
   } linkPhase_e;

   typedef struct packed {
      logic       isK;
      logic [7:0] octet;
   } laneChar_s;

   // Header sits in the low bits: position 0 is bit 0
   typedef struct packed {
      logic [63:0] payload;
      logic [1:0]  header;
   } block66_s;

   typedef struct packed {
      logic [7:0] octetsPerFrameM1;
      logic [7:0] framesPerMfM1;
      logic [7:0] convertersM1;
      logic [4:0] resolutionM1;
      logic [4:0] mbPerEmbM1;
      logic       scrambleEnable;
      logic       encMode64;
   } linkCfg_s;
endpackage

// [logic/lane_char_map.sv]
// Purpose: Per-lane octet path: comma stream, ILAS pass-through, scrambling, alignment characters
// Assumes: Phase and frame position arrive in the same cycle as the octet
// Notes:   Output is registered, one cycle behind its inputs
`timescale 1ns/10ps
module lane_char_map import jesd_align_pkg::*; (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  linkPhase_e      phase,
   input  laneChar_s       ilasChar,
   input  wire logic [7:0] dataOctet,
   input  wire logic       frameEnd,
   input  wire logic       mfEnd,
   input  wire logic       scrambleEnable,
   output laneChar_s       laneChar
);
   function automatic logic [22:0] scramble8(input logic [14:0] st, input logic [7:0] d);
      logic [14:0] s;
      logic [7:0]  q;
      s = st;
      q = '0;
      for (int i = 7; i >= 0; i--) begin
         q[i] = d[i] ^ s[SCR8_TAP_A] ^ s[SCR8_TAP_B];
         s    = {s[13:0], q[i]};
      end
      return {s, q};
   endfunction

   laneChar_s   char_r, char_nxt;
   logic [14:0] scram_r, scram_nxt, scramStep;
   logic [7:0]  prev_r, prev_nxt, scramOctet, sendOctet;
   logic        prevValid_r, prevValid_nxt;

   always_comb begin
      {scramStep, scramOctet} = scramble8(scram_r, dataOctet);
      sendOctet     = scrambleEnable ? scramOctet : dataOctet;
      char_nxt      = '{isK: 1'b0, octet: sendOctet};
      scram_nxt     = scram_r;
      prev_nxt      = prev_r;
      prevValid_nxt = prevValid_r;
      unique case (phase)
         PH_CGS, PH_WAIT: begin
            char_nxt      = '{isK: 1'b1, octet: K28_5};
            prevValid_nxt = 1'b0;
         end
         PH_ILAS: begin
            // Scrambler is frozen so ILAS octets go out in clear
            char_nxt      = ilasChar;
            prevValid_nxt = 1'b0;
         end
         PH_DATA: begin
            if (scrambleEnable) begin
               scram_nxt = scramStep;
            end
            if (frameEnd) begin
               prev_nxt      = sendOctet;
               prevValid_nxt = 1'b1;
               if (scrambleEnable) begin
                  if (mfEnd && sendOctet == MF_END_MATCH) begin
                     char_nxt = '{isK: 1'b1, octet: K28_3};
                  end else if (sendOctet == FRAME_END_MATCH) begin
                     char_nxt = '{isK: 1'b1, octet: K28_7};
                  end
               end else if (prevValid_r && sendOctet == prev_r) begin
                  char_nxt = '{isK: 1'b1, octet: mfEnd ? K28_3 : K28_7};
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         char_r      <= '{isK: 1'b1, octet: K28_5};
         scram_r     <= SCR8_SEED;
         prev_r      <= '0;
         prevValid_r <= 1'b0;
      end else begin
         char_r      <= char_nxt;
         scram_r     <= scram_nxt;
         prev_r      <= prev_nxt;
         prevValid_r <= prevValid_nxt;
      end
   end

   assign laneChar = char_r;

   property p_comma;
      @(posedge clk) disable iff (!nrst)
      (phase == PH_CGS) |=> (laneChar.isK && laneChar.octet == K28_5);
   endproperty
   a_comma: assert property (p_comma) else $error("Comma missing while link idle");

   property p_ilasClear;
      @(posedge clk) disable iff (!nrst)
      (phase == PH_ILAS) |=> (laneChar == $past(ilasChar) && $stable(scram_r));
   endproperty
   a_ilasClear: assert property (p_ilasClear) else $error("ILAS octet altered");

   property p_scramFrame;
      @(posedge clk) disable iff (!nrst)
      (phase == PH_DATA && scrambleEnable && frameEnd && !mfEnd && scramOctet == FRAME_END_MATCH)
      |=> (laneChar.isK && laneChar.octet == K28_7);
   endproperty
   a_scramFrame: assert property (p_scramFrame) else $error("Scrambled frame end not marked");

   property p_repeatMf;
      @(posedge clk) disable iff (!nrst)
      (phase == PH_DATA && !scrambleEnable && frameEnd && mfEnd && prevValid_r && dataOctet == prev_r)
      |=> (laneChar.isK && laneChar.octet == K28_3);
   endproperty
   a_repeatMf: assert property (p_repeatMf) else $error("Repeated multiframe end not marked");

   property p_plainData;
      @(posedge clk) disable iff (!nrst)
      (phase == PH_DATA && !frameEnd) |=> !laneChar.isK;
   endproperty
   a_plainData: assert property (p_plainData) else $error("Control code inside a frame");
endmodule

// [logic/jesd_link_align.sv]
// Purpose: Transmit link-layer framing: LMFC/LEMC timing, SYNC handshake, ILAS, alignment chars, 66-bit blocks
// Assumes: 8B/10B side takes one octet per lane per clock, 64B/66B side one block per lane per clock
// Notes:   Sync header stream content comes from outside; only its bit per block is taken here
`timescale 1ns/10ps
module jesd_link_align import jesd_align_pkg::*; (
   input  wire logic                   clk,
   input  wire logic                   nrst,
   input  wire logic                   linkSyncN,
   input  wire logic                   sysref,
   input  linkCfg_s                    cfg,
   input  wire logic [LANES-1:0][7:0]  sampleOctets,
   input  wire logic [LANES-1:0][63:0] sampleBlocks,
   input  wire logic [LANES-1:0]       shBits,
   output logic                        sampleReady,
   output laneChar_s [LANES-1:0]       laneChars,
   output block66_s  [LANES-1:0]       laneBlocks,
   output logic                        lmfcEdge,
   output logic                        lemcEdge,
   output linkPhase_e                  linkPhase,
   output logic                        cfgError
);
   function automatic logic [121:0] scramble66(input logic [57:0] st, input logic [63:0] d);
      logic [57:0] s;
      logic [63:0] q;
      s = st;
      q = '0;
      // Bit 0 of the payload goes out first
      for (int i = 0; i < 64; i++) begin
         q[i] = d[i] ^ s[SCR66_TAP_A] ^ s[SCR66_TAP_B];
         s    = {s[56:0], q[i]};
      end
      return {s, q};
   endfunction

   function automatic logic [7:0] cfgOctet(input logic [9:0] idx, input logic [7:0] laneId, input linkCfg_s c);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         10'h000: v = laneId;
         10'h001: v = c.octetsPerFrameM1;
         10'h002: v = c.framesPerMfM1;
         10'h003: v = c.convertersM1;
         10'h004: v = {c.scrambleEnable, 2'h0, c.resolutionM1};
         10'h005: v = {3'h0, c.mbPerEmbM1};
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   function automatic laneChar_s ilasCharAt(input logic [1:0] mfIdx, input logic [9:0] pos, input logic mfLast,
                                            input logic [7:0] laneId, input linkCfg_s c);
      laneChar_s ch;
      ch = '{isK: 1'b0, octet: pos[7:0]};
      if (pos == 10'h000) begin
         ch = '{isK: 1'b1, octet: K28_0};
      end else if (mfLast) begin
         ch = '{isK: 1'b1, octet: K28_3};
      end else if (mfIdx == ILAS_CFG_MF && pos == ILAS_Q_POS) begin
         ch = '{isK: 1'b1, octet: K28_4};
      end else if (mfIdx == ILAS_CFG_MF && pos >= ILAS_CFG_POS && pos < ILAS_CFG_POS + ILAS_CFG_LEN) begin
         ch = '{isK: 1'b0, octet: cfgOctet(pos - ILAS_CFG_POS, laneId, c)};
      end
      return ch;
   endfunction

   linkPhase_e  state_r, state_nxt;
   logic [7:0]  octetCnt_r, octetCnt_nxt;
   logic [7:0]  frameCnt_r, frameCnt_nxt;
   logic [9:0]  mfPos_r, mfPos_nxt;
   logic [1:0]  ilasMf_r, ilasMf_nxt;
   logic [4:0]  blkCnt_r, blkCnt_nxt;
   logic        syncPrev_r, sysrefPrev_r;
   logic        syncRise, sysrefRise, frameEnd, mfEnd, lmfcStartNxt;
   logic [8:0]  octetsPerFrame;

   assign syncRise       = linkSyncN && !syncPrev_r;
   assign sysrefRise     = sysref && !sysrefPrev_r;
   assign frameEnd       = (octetCnt_r == cfg.octetsPerFrameM1);
   assign mfEnd          = frameEnd && (frameCnt_r == cfg.framesPerMfM1);
   assign octetsPerFrame = {1'b0, cfg.octetsPerFrameM1} + 9'h001;

   // Multiframe and multiblock counters, both phased by SYSREF
   always_comb begin
      octetCnt_nxt = octetCnt_r + 8'h01;
      frameCnt_nxt = frameCnt_r;
      mfPos_nxt    = mfPos_r + 10'h001;
      blkCnt_nxt   = (blkCnt_r == MB_LAST_BLOCK) ? 5'h00 : blkCnt_r + 5'h01;
      if (sysrefRise) begin
         octetCnt_nxt = 8'h00;
         frameCnt_nxt = 8'h00;
         mfPos_nxt    = 10'h000;
         blkCnt_nxt   = 5'h00;
      end else if (frameEnd) begin
         octetCnt_nxt = 8'h00;
         if (mfEnd) begin
            frameCnt_nxt = 8'h00;
            mfPos_nxt    = 10'h000;
         end else begin
            frameCnt_nxt = frameCnt_r + 8'h01;
         end
      end
   end

   assign lmfcStartNxt = (octetCnt_nxt == 8'h00) && (frameCnt_nxt == 8'h00);

   always_comb begin
      state_nxt  = state_r;
      ilasMf_nxt = ilasMf_r;
      if (cfg.encMode64 || !linkSyncN) begin
         state_nxt  = PH_CGS;
         ilasMf_nxt = 2'h0;
      end else begin
         unique case (state_r)
            PH_CGS: begin
               if (syncRise) begin
                  state_nxt = PH_WAIT;
               end
            end
            PH_WAIT: begin
               if (lmfcStartNxt) begin
                  state_nxt  = PH_ILAS;
                  ilasMf_nxt = 2'h0;
               end
            end
            PH_ILAS: begin
               if (mfEnd) begin
                  if (ilasMf_r == ILAS_LAST_MF) begin
                     state_nxt = PH_DATA;
                  end else begin
                     ilasMf_nxt = ilasMf_r + 2'h1;
                  end
               end
            end
            PH_DATA: state_nxt = PH_DATA;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r      <= PH_CGS;
         octetCnt_r   <= 8'h00;
         frameCnt_r   <= 8'h00;
         mfPos_r      <= 10'h000;
         ilasMf_r     <= 2'h0;
         blkCnt_r     <= 5'h00;
         syncPrev_r   <= 1'b0;
         sysrefPrev_r <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         octetCnt_r   <= octetCnt_nxt;
         frameCnt_r   <= frameCnt_nxt;
         mfPos_r      <= mfPos_nxt;
         ilasMf_r     <= ilasMf_nxt;
         blkCnt_r     <= blkCnt_nxt;
         syncPrev_r   <= linkSyncN;
         sysrefPrev_r <= sysref;
      end
   end

   // Per-lane octet path, each with its own scrambler and last-octet memory
   for (genvar ln = 0; ln < LANES; ln++) begin : g_lane
      lane_char_map u_map (
         .clk            (clk),
         .nrst           (nrst),
         .phase          (state_r),
         .ilasChar       (ilasCharAt(ilasMf_r, mfPos_r, mfEnd, 8'(ln), cfg)),
         .dataOctet      (sampleOctets[ln]),
         .frameEnd       (frameEnd),
         .mfEnd          (mfEnd),
         .scrambleEnable (cfg.scrambleEnable),
         .laneChar       (laneChars[ln])
      );
   end

   // 64B/66B path: scrambler always on in this mode
   logic [LANES-1:0][57:0] scr66_r, scr66_nxt;
   block66_s [LANES-1:0]   blk_r, blk_nxt;

   always_comb begin
      scr66_nxt = scr66_r;
      blk_nxt   = blk_r;
      for (int ln = 0; ln < LANES; ln++) begin
         if (cfg.encMode64) begin
            {scr66_nxt[ln], blk_nxt[ln].payload} = scramble66(scr66_r[ln], sampleBlocks[ln]);
            blk_nxt[ln].header = shBits[ln] ? SH_ONE : SH_ZERO;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int ln = 0; ln < LANES; ln++) begin
            scr66_r[ln] <= SCR66_SEED;
            blk_r[ln]   <= '{payload: 64'h0, header: SH_ZERO};
         end
      end else begin
         scr66_r <= scr66_nxt;
         blk_r   <= blk_nxt;
      end
   end

   // A 256-octet multiblock holds whole frames only for power-of-two F
   assign cfgError    = (cfg.mbPerEmbM1 != 5'h00) || ((octetsPerFrame & (octetsPerFrame - 9'h001)) != 9'h000);
   assign sampleReady = cfg.encMode64 || (state_r == PH_DATA);
   assign laneBlocks  = blk_r;
   assign lmfcEdge    = (octetCnt_r == 8'h00) && (frameCnt_r == 8'h00);
   assign lemcEdge    = (blkCnt_r == 5'h00);
   assign linkPhase   = state_r;

   // Helper: cycles spent in ILAS
   logic [19:0] ilasLen_r;
   logic [19:0] ilasExpect;
   assign ilasExpect = 20'(ILAS_MULTIFRAMES) * 20'(octetsPerFrame) * (20'(cfg.framesPerMfM1) + 20'h00001);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ilasLen_r <= 20'h00000;
      end else if (state_r == PH_ILAS) begin
         ilasLen_r <= ilasLen_r + 20'h00001;
      end else begin
         ilasLen_r <= 20'h00000;
      end
   end

   sequence s_syncRise;
      (state_r == PH_CGS) && !cfg.encMode64 && syncRise;
   endsequence

   property p_syncToWait;
      @(posedge clk) disable iff (!nrst)
      s_syncRise |=> (state_r == PH_WAIT || !linkSyncN);
   endproperty
   a_syncToWait: assert property (p_syncToWait) else $error("SYNC rise not seen");

   property p_ilasOnEdge;
      @(posedge clk) disable iff (!nrst)
      $rose(state_r == PH_ILAS) |-> (octetCnt_r == 8'h00 && frameCnt_r == 8'h00 && $past(state_r) == PH_WAIT);
   endproperty
   a_ilasOnEdge: assert property (p_ilasOnEdge) else $error("ILAS off the LMFC edge");

   property p_ilasLength;
      @(posedge clk) disable iff (!nrst)
      ($past(state_r) == PH_ILAS && state_r == PH_DATA && !$past(sysrefRise)) |-> (ilasLen_r == ilasExpect
         && $past(ilasLen_r) + 20'h00001 == ilasExpect);
   endproperty
   a_ilasLength: assert property (p_ilasLength) else $error("ILAS length not four multiframes");

   property p_ilasOpen;
      @(posedge clk) disable iff (!nrst)
      (state_r == PH_ILAS && mfPos_r == 10'h000) |=> (laneChars[0].isK && laneChars[0].octet == K28_0);
   endproperty
   a_ilasOpen: assert property (p_ilasOpen) else $error("ILAS multiframe not opened by K28.0");

   property p_sysrefPhase;
      @(posedge clk) disable iff (!nrst)
      sysrefRise |=> (lemcEdge && lmfcEdge);
   endproperty
   a_sysrefPhase: assert property (p_sysrefPhase) else $error("SYSREF did not reset clocks");

   property p_mbWrap;
      @(posedge clk) disable iff (!nrst)
      (blkCnt_r == MB_LAST_BLOCK && !sysrefRise) |=> (blkCnt_r == 5'h00) ##1 (blkCnt_r == 5'h01 || $past(sysrefRise));
   endproperty
   a_mbWrap: assert property (p_mbWrap) else $error("Multiblock not 32 blocks");

   property p_header;
      @(posedge clk) disable iff (!nrst)
      cfg.encMode64 |=> (laneBlocks[0].header == ($past(shBits[0]) ? SH_ONE : SH_ZERO));
   endproperty
   a_header: assert property (p_header) else $error("Sync header wrong");

   property p_cfgE;
      @(posedge clk) disable iff (!nrst)
      (cfg.mbPerEmbM1 != 5'h00) |-> cfgError;
   endproperty
   a_cfgE: assert property (p_cfgE) else $error("Multiblock count above one accepted");
endmodule

// [test/jesd_rx_model.sv]
// Purpose: Receiver-side partner for the link, watching one lane
// Assumes: Same F and K as the transmitter, shared sysref
// Notes:   Self-synchronous descrambler needs two octets to lock
`timescale 1ns/10ps
module jesd_rx_model import jesd_align_pkg::*; #(
   parameter int F  = 2,
   parameter int FK = 18
) (
   input  wire logic  clk,
   input  wire logic  nrst,
   input  wire logic  sysref,
   input  wire logic  holdSync,
   input  wire logic  scrambleEnable,
   input  laneChar_s  rxChar,
   output logic       linkSyncN,
   output logic [7:0] rxOctet,
   output logic [7:0] misalignCnt
);
   logic [7:0]  cnt, pos, prevEnd, d;
   logic [14:0] s, sN;
   logic [2:0]  commas, aCnt;
   logic        sysrefQ, inData, fEnd, mEnd, bad;

   always_comb begin
      fEnd = pos % F == F - 1;
      mEnd = pos == FK - 1;
      bad  = inData && rxChar.isK && !(fEnd && rxChar.octet == K28_7 || mEnd && rxChar.octet == K28_3);
      sN   = s;
      for (int b = 7; b >= 0; b--) begin
         d[b] = rxChar.octet[b] ^ sN[13] ^ sN[14];
         sN   = {sN[13:0], rxChar.octet[b]};
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         {cnt, pos, prevEnd, rxOctet, misalignCnt, commas, aCnt} <= '0;
         {sysrefQ, inData, linkSyncN} <= '0;
         s <= '0;
      end else begin
         sysrefQ <= sysref;
         cnt     <= (sysref && !sysrefQ) || cnt == 8'(FK - 1) ? 8'h00 : cnt + 8'h01;
         pos     <= cnt;
         if (bad)
            misalignCnt <= misalignCnt + 8'h01;
         if (holdSync || bad) begin
            linkSyncN <= 1'b0;
            inData    <= 1'b0;
            aCnt      <= 3'h0;
            commas    <= 3'h0;
         end else if (!linkSyncN) begin
            commas <= rxChar == {1'b1, K28_5} ? (commas == 3'h4 ? commas : commas + 3'h1) : 3'h0;
            // Release only on own multiframe edge, as a real receiver would
            if (commas == 3'h4 && cnt == 8'h00)
               linkSyncN <= 1'b1;
         end else if (!inData) begin
            aCnt   <= aCnt + 3'(rxChar == {1'b1, K28_3});
            inData <= aCnt == 3'h3 && rxChar == {1'b1, K28_3};
         end else begin
            if (scrambleEnable) begin
               s       <= sN;
               rxOctet <= d;
            end else
               rxOctet <= rxChar.isK ? prevEnd : rxChar.octet;
            if (fEnd && !rxChar.isK)
               prevEnd <= rxChar.octet;
         end
      end
   end
endmodule

// [test/jesd_link_align_tb_top.sv]
// Purpose: Self-checking bench for the transmit alignment block
// Assumes: F=2, K=9; partner watches lane 2
// Notes:   Monitor samples on the falling edge, stimulus moves on the rising edge
`timescale 1ns/10ps
module jesd_link_align_tb_top import jesd_align_pkg::*;;
   localparam int F  = 2;
   localparam int K  = 9;
   localparam int FK = F * K;
   logic                   clk, nrst, linkSyncN, sysref, holdSync, sampleReady, lmfcEdge, lemcEdge, cfgError, lmfcQ;
   linkCfg_s               cfg;
   logic [LANES-1:0][7:0]  sampleOctets, d0, d1, d2;
   logic [LANES-1:0][63:0] sampleBlocks;
   logic [LANES-1:0]       shBits, h0, h1;
   logic [63:0]            b0, b1;
   laneChar_s [LANES-1:0]  laneChars;
   block66_s  [LANES-1:0]  laneBlocks;
   linkPhase_e             linkPhase;
   logic [7:0]             rxOctet, misalignCnt, seq;
   int                     pos, nErrors, checksDone;

   jesd_link_align dut_u (.clk(clk), .nrst(nrst), .linkSyncN(linkSyncN), .sysref(sysref), .cfg(cfg),
      .sampleOctets(sampleOctets), .sampleBlocks(sampleBlocks), .shBits(shBits), .sampleReady(sampleReady),
      .laneChars(laneChars), .laneBlocks(laneBlocks), .lmfcEdge(lmfcEdge), .lemcEdge(lemcEdge),
      .linkPhase(linkPhase), .cfgError(cfgError));
   jesd_rx_model #(.F(F), .FK(FK)) partner_u (.clk(clk), .nrst(nrst), .sysref(sysref), .holdSync(holdSync),
      .scrambleEnable(cfg.scrambleEnable), .rxChar(laneChars[2]), .linkSyncN(linkSyncN), .rxOctet(rxOctet),
      .misalignCnt(misalignCnt));

   always #(CLK_PERIOD_NS / 2) clk = ~clk;

   // Lane 0 never repeats at frame end, lane 1 always does, lane 2 half the time
   always @(posedge clk) begin
      if (!nrst) begin
         seq          <= 8'h00;
         sampleOctets <= '0;
         sampleBlocks <= '0;
         shBits       <= '0;
      end else begin
         seq          <= seq + 8'h01;
         sampleOctets <= {8'hAA, seq >> 2, 8'h55, seq};
         sampleBlocks <= {LANES{seq, ~seq, 16'hA5C3, seq + 8'h11, 24'h13579B}};
         shBits       <= seq[3:0];
      end
   end

   task automatic chk(input string what, input logic [65:0] expV, input logic [65:0] gotV);
      checksDone++;
      if (gotV !== expV) begin
         nErrors++;
         $display("[FAIL] %s expected %h seen %h", what, expV, gotV);
      end
   endtask

   task automatic giveVerdict();
      $display("checks %0d errors %0d", checksDone, nErrors);
      if (nErrors == 0 && checksDone > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic step();
      @(negedge clk);
      pos   = lmfcQ ? 0 : pos + 1;
      lmfcQ = lmfcEdge;
      d2    = d1;
      d1    = d0;
      d0    = sampleOctets;
      h1    = h0;
      h0    = shBits;
      b1    = b0;
      b0    = sampleBlocks[0];
   endtask

   task automatic period_check(input bit lemc, input int n);
      @(posedge clk);
      sysref <= 1'b1;
      step();
      @(posedge clk);
      sysref <= 1'b0;
      step();
      for (int i = 0; i <= n; i++) begin
         chk("timing edge", i == 0 || i == n, lemc ? lemcEdge : lmfcEdge);
         step();
      end
   endtask

   task automatic comma_check();
      @(posedge clk);
      holdSync <= 1'b1;
      repeat (4) step();
      for (int l = 0; l < LANES; l++)
         chk("comma", {1'b1, K28_5}, laneChars[l]);
      chk("phase", PH_CGS, linkPhase);
   endtask

   task automatic cfg_check();
      chk("config error", 1'b0, cfgError);
      @(posedge clk);
      cfg.mbPerEmbM1 <= 5'h01;
      step();
      chk("config error", 1'b1, cfgError);
      @(posedge clk);
      cfg.mbPerEmbM1 <= 5'h00;
      step();
   endtask

   task automatic link_up();
      int         n, p;
      logic [8:0] e;
      logic [8:0] cf [8];
      @(posedge clk);
      holdSync <= 1'b0;
      // Read after the edge so a config change just made has landed
      cf = '{9'h000, {1'b1, K28_4}, 9'h000, {1'b0, 8'(F - 1)}, {1'b0, 8'(K - 1)}, {1'b0, cfg.convertersM1},
             {1'b0, cfg.scrambleEnable, 2'b00, cfg.resolutionM1}, {4'h0, cfg.mbPerEmbM1}};
      n = 0;
      do begin
         step();
         n++;
      end while (linkPhase !== PH_ILAS && n < 200);
      chk("start edge", {1'b1, PH_ILAS}, {lmfcEdge, linkPhase});
      for (int i = 0; i < 4 * FK; i++) begin
         step();
         p = i % FK;
         e = {1'b0, 8'(p)};
         if (i / FK == 1 && p < 8)
            e = cf[p];
         if (p == 0 || p == FK - 1)
            e = {1'b1, p == 0 ? K28_0 : K28_3};
         if (i < 4 * FK - 1)
            chk("ilas phase", PH_ILAS, linkPhase);
         for (int l = 0; l < LANES; l++)
            chk("ilas char", (i / FK == 1 && p == 2) ? {1'b0, 8'(l)} : e, laneChars[l]);
      end
      chk("data phase", {1'b1, PH_DATA}, {sampleReady, linkPhase});
   endtask

   task automatic data_run(input int n);
      logic [LANES-1:0][7:0] last;
      logic                  seen, fe, me;
      laneChar_s             c;
      logic [8:0]            e;
      seen = 1'b0;
      last = '0;
      for (int i = 0; i < n; i++) begin
         step();
         fe = pos % F == F - 1;
         me = pos == FK - 1;
         for (int l = 0; l < LANES; l++) begin
            c = laneChars[l];
            e = {fe && seen && d1[l] == last[l], d1[l]};
            if (e[8])
               e[7:0] = me ? K28_3 : K28_7;
            if (cfg.scrambleEnable)
               chk("scrambled flag", fe && (c.octet == K28_7 || me && c.octet == K28_3), c.isK);
            else
               chk("lane char", e, c);
            if (fe)
               last[l] = d1[l];
         end
         seen = seen | fe;
         if (i > 5)
            chk("partner octet", d2[2], rxOctet);
      end
      chk("misalignment count", 8'h00, misalignCnt);
   endtask

   task automatic block_check();
      logic [57:0] s;
      logic [63:0] pd;
      logic        c;
      @(posedge clk);
      cfg.encMode64 <= 1'b1;
      holdSync      <= 1'b0;
      period_check(1'b1, BLOCKS_PER_MB);
      chk("block mode phase", PH_CGS, linkPhase);
      s = '0;
      for (int i = 0; i < 20; i++) begin
         step();
         for (int l = 0; l < LANES; l++)
            chk("sync header", h1[l] ? 2'h2 : 2'h1, laneBlocks[l].header);
         for (int j = 0; j < 64; j++) begin
            c     = laneBlocks[0].payload[j];
            pd[j] = c ^ s[38] ^ s[57];
            s     = {s[56:0], c};
         end
         if (i > 1)
            chk("block payload", b1, pd);
      end
   endtask

   initial begin
      clk          = 1'b0;
      nrst         = 1'b0;
      sysref       = 1'b0;
      holdSync     = 1'b1;
      cfg          = '{8'(F - 1), 8'(K - 1), 8'h01, 5'h07, 5'h00, 1'b0, 1'b0};
      nErrors      = 0;
      checksDone   = 0;
      pos          = 0;
      lmfcQ        = 1'b0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      comma_check();
      cfg_check();
      period_check(1'b0, FK);
      link_up();
      data_run(120);
      comma_check();
      @(posedge clk);
      cfg.scrambleEnable <= 1'b1;
      link_up();
      data_run(300);
      comma_check();
      block_check();
      giveVerdict();
   end

   // Whole run is under a thousand cycles
   initial begin
      #(CLK_PERIOD_NS * 5000);
      nErrors++;
      giveVerdict();
   end
endmodule
